// ### verilog/charge_protect_pkg.sv
`default_nettype none
package charge_protect_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int MEAS_W = 16;
    localparam int CUR_CODE_W = 7;
    localparam int OV_CODE_W = 3;
    localparam int INT_W = 2;

    // register offsets
    localparam logic [7:0] OFF_ALARM_CFG = 8'h04;
    localparam logic [7:0] OFF_SURGE_CTRL = 8'h05;
    localparam logic [7:0] OFF_INT_STATUS = 8'h10;
    localparam logic [7:0] OFF_INT_MASK = 8'h11;
    localparam logic [7:0] OFF_SOFT_RESET = 8'h12;

    // values after reset
    localparam logic [7:0] RST_ALARM_CFG = 8'h28;
    localparam logic [7:0] RST_SURGE_CTRL = 8'h03;
    localparam logic [1:0] RST_INT_MASK = 2'h0;

    // field positions
    localparam int ALARM_DIS_BIT = 7;
    localparam int OV_STAT_BIT = 7;
    localparam int OV_FLAG_BIT = 6;
    localparam int OV_MASK_BIT = 5;
    localparam int SOFT_RESET_BIT = 0;
    localparam int INT_LOW_CUR_BIT = 0;
    localparam int INT_OV_BIT = 1;

    // threshold arithmetic, millamps and millivolts
    localparam logic [15:0] LOW_CUR_STEP_MA = 16'h0032; // 50 mA
    localparam logic [15:0] OV_BASE_MV = 16'h2af8; // 11 V
    localparam logic [15:0] OV_STEP_MV = 16'h03e8; // 1 V
    localparam logic [15:0] OV_SPECIAL_MV = 16'h1964; // 6.5 V
    localparam logic [2:0] OV_SPECIAL_CODE = 3'h7;

    function automatic logic [15:0] low_cur_threshold_ma(input logic [6:0] code);
        return 16'({9'h000, code} * LOW_CUR_STEP_MA);
    endfunction

    function automatic logic [15:0] ov_threshold_mv(input logic [2:0] code);
        if (code == OV_SPECIAL_CODE) begin
            return OV_SPECIAL_MV;
        end
        return 16'(OV_BASE_MV + 16'({13'h0000, code} * OV_STEP_MV));
    endfunction
endpackage
`default_nettype wire

// ### verilog/protect_cmp_if.sv
`default_nettype none
interface protect_cmp_if;
    logic [6:0] cur_code;
    logic [2:0] ov_code;
    logic [15:0] batt_ma;
    logic [15:0] vin_mv;
    logic below;
    logic over;
    modport regs(output cur_code, ov_code, batt_ma, vin_mv, input below, over);
    modport cmp(input cur_code, ov_code, batt_ma, vin_mv, output below, over);
endinterface
`default_nettype wire

// ### verilog/protect_compare.sv
`default_nettype none
module protect_compare (
    input wire logic ref_clk,
    input wire logic sys_rst,
    protect_cmp_if.cmp bus
);
    import charge_protect_pkg::*;

    // decoded thresholds
    wire logic [15:0] cur_thr_ma;
    wire logic [15:0] ov_thr_mv;
    assign cur_thr_ma = low_cur_threshold_ma(bus.cur_code);
    assign ov_thr_mv = ov_threshold_mv(bus.ov_code);

    // registered compares; one cycle of latency keeps the adder off the irq path
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            bus.below <= 1'b0;
            bus.over <= 1'b0;
        end else begin
            bus.below <= bus.batt_ma < cur_thr_ma;
            bus.over <= bus.vin_mv >= ov_thr_mv;
        end
    end

    AST_LOW_THRESH: assert property (@(posedge ref_clk) disable iff (sys_rst)
        1'b1 |=> bus.below == ($past(bus.batt_ma) < 16'($past({9'h000, bus.cur_code}) * 50)))
        else $error("low current compare wrong");
    AST_OV_LINEAR: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus.ov_code != 3'h7 |=> bus.over ==
        ($past(bus.vin_mv) >= 16'(11000 + 1000 * $past({13'h0000, bus.ov_code}))))
        else $error("linear overvoltage threshold wrong");
    AST_OV_SPECIAL: assert property (@(posedge ref_clk) disable iff (sys_rst)
        bus.ov_code == 3'h7 |=> bus.over == ($past(bus.vin_mv) >= 16'h1964))
        else $error("special overvoltage threshold wrong");
endmodule
`default_nettype wire

// ### verilog/charge_protect_alarm_regs.sv
`default_nettype none
module charge_protect_alarm_regs (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [charge_protect_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [charge_protect_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [charge_protect_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [charge_protect_pkg::MEAS_W-1:0] battery_current_ma,
    input wire logic [charge_protect_pkg::MEAS_W-1:0] input_voltage_mv,
    output logic host_irq,
    output logic protection_fet_gate_drive
);
    import charge_protect_pkg::*;

    protect_cmp_if cmp_bus();

    logic [7:0] alarm_cfg;
    logic ov_mask;
    logic [2:0] ov_thr;
    logic ov_flag;
    logic [1:0] int_status;
    logic [1:0] int_mask;
    logic prev_below;
    logic prev_over;

    // address decode
    wire logic hit_alarm;
    wire logic hit_surge;
    wire logic hit_status;
    wire logic hit_mask;
    wire logic hit_soft;
    assign hit_alarm = reg_addr == OFF_ALARM_CFG;
    assign hit_surge = reg_addr == OFF_SURGE_CTRL;
    assign hit_status = reg_addr == OFF_INT_STATUS;
    assign hit_mask = reg_addr == OFF_INT_MASK;
    assign hit_soft = reg_addr == OFF_SOFT_RESET;

    // strobes; soft reset is a write-one pulse that never stores
    wire logic wr_alarm;
    wire logic wr_surge;
    wire logic wr_mask;
    wire logic rd_surge;
    wire logic rd_status;
    wire logic soft_rst;
    assign wr_alarm = reg_wr && hit_alarm;
    assign wr_surge = reg_wr && hit_surge;
    assign wr_mask = reg_wr && hit_mask;
    assign rd_surge = reg_rd && hit_surge;
    assign rd_status = reg_rd && hit_status;
    assign soft_rst = reg_wr && hit_soft && reg_wdata[SOFT_RESET_BIT];

    // measurements and settings out to the comparators
    assign cmp_bus.cur_code = alarm_cfg[6:0];
    assign cmp_bus.ov_code = ov_thr;
    assign cmp_bus.batt_ma = battery_current_ma;
    assign cmp_bus.vin_mv = input_voltage_mv;

    protect_compare u_compare (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .bus(cmp_bus)
    );

    // events are the rising edges of the compare levels
    wire logic alarm_dis;
    wire logic low_evt;
    wire logic ov_evt;
    assign alarm_dis = alarm_cfg[ALARM_DIS_BIT];
    assign low_evt = cmp_bus.below && !prev_below;
    assign ov_evt = cmp_bus.over && !prev_over;

    // next values of the sticky bits; a set in the clearing cycle wins
    wire logic next_flag;
    wire logic [1:0] int_set;
    wire logic [1:0] next_status;
    assign next_flag = (ov_flag && !rd_surge) || ov_evt;
    assign int_set[INT_LOW_CUR_BIT] = low_evt && !alarm_dis;
    assign int_set[INT_OV_BIT] = ov_evt && !ov_mask;
    assign next_status = (int_status & ~{2{rd_status}}) | int_set;

    // read view; reserved bits read as zero, unmapped addresses as zero
    wire logic [7:0] surge_view;
    wire logic [7:0] rd_mux;
    assign surge_view = {cmp_bus.over, ov_flag, ov_mask, 2'b00, ov_thr};
    assign rd_mux = hit_alarm ? alarm_cfg :
                    hit_surge ? surge_view :
                    hit_status ? {6'h00, int_status} :
                    hit_mask ? {6'h00, int_mask} : 8'h00;

    // read data registered; stands only in the cycle after the strobe
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // writable fields; read-only bits of a write are simply dropped
    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_rst) begin
            alarm_cfg <= RST_ALARM_CFG;
            ov_mask <= RST_SURGE_CTRL[OV_MASK_BIT];
            ov_thr <= RST_SURGE_CTRL[2:0];
            int_mask <= RST_INT_MASK;
        end else begin
            if (wr_alarm) begin
                alarm_cfg <= reg_wdata;
            end
            if (wr_surge) begin
                ov_mask <= reg_wdata[OV_MASK_BIT];
                ov_thr <= reg_wdata[2:0];
            end
            if (wr_mask) begin
                int_mask <= reg_wdata[1:0];
            end
        end
    end

    // sticky flags; soft reset drops an event landing in the same cycle
    always_ff @(posedge ref_clk) begin
        if (sys_rst || soft_rst) begin
            ov_flag <= 1'b0;
            int_status <= 2'h0;
        end else begin
            ov_flag <= next_flag;
            int_status <= next_status;
        end
    end

    // edge memory is not a register field, so soft reset leaves it
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            prev_below <= 1'b0;
            prev_over <= 1'b0;
        end else begin
            prev_below <= cmp_bus.below;
            prev_over <= cmp_bus.over;
        end
    end

    // gate held off in reset so the FET never opens before thresholds are known
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            protection_fet_gate_drive <= 1'b0;
        end else begin
            protection_fet_gate_drive <= !cmp_bus.over;
        end
    end

    // level interrupt straight from the sticky and mask flops
    assign host_irq = |(int_status & ~int_mask);

    default clocking dflt_cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    AST_STAT_LIVE: assert property (
        reg_rd && hit_surge |=> reg_rdata[OV_STAT_BIT] == $past(cmp_bus.over))
        else $error("status bit does not follow condition");
    AST_FLAG_SET: assert property (
        ov_evt && !soft_rst |=> ov_flag)
        else $error("event flag not set");
    AST_FLAG_CLR: assert property (
        rd_surge && !ov_evt && !soft_rst |=> !ov_flag)
        else $error("event flag not cleared by read");
    AST_MASK: assert property (
        ov_mask && !int_status[INT_OV_BIT] |=> !int_status[INT_OV_BIT])
        else $error("masked overvoltage raised status");
    AST_LOW_ALARM: assert property (
        low_evt && !alarm_dis && !soft_rst |=> int_status[INT_LOW_CUR_BIT]
        ##0 (host_irq || int_mask[INT_LOW_CUR_BIT]))
        else $error("low current alarm not raised");
    AST_LOW_DIS: assert property (
        alarm_dis && !int_status[INT_LOW_CUR_BIT] |=> !int_status[INT_LOW_CUR_BIT])
        else $error("disabled alarm raised status");
    AST_GATE: assert property (
        cmp_bus.over |=> !protection_fet_gate_drive)
        else $error("gate not driven off on overvoltage");
    AST_SOFT_RST: assert property (
        soft_rst |=> alarm_cfg == RST_ALARM_CFG && ov_thr == RST_SURGE_CTRL[2:0]
        && !ov_mask && !ov_flag && int_status == 2'h0)
        else $error("soft reset left a field changed");
    AST_RSVD: assert property (
        reg_rd && hit_surge |=> reg_rdata[4:3] == 2'b00)
        else $error("reserved bits not zero");
    AST_RO_WRITE: assert property (
        wr_surge && !ov_evt |=> ov_flag == $past(ov_flag)
        && alarm_cfg == $past(alarm_cfg))
        else $error("write touched read-only state");

    COV_OV_EVENT: cover property (ov_evt ##1 ov_flag ##[1:20] rd_surge);
    COV_LOW_IRQ: cover property (low_evt && !alarm_dis ##1 host_irq);
    COV_SET_CLEAR: cover property (rd_status && |int_set);
    COV_SOFT_RST: cover property (soft_rst);
endmodule
`default_nettype wire

// ### tb/charge_protect_alarm_regs_tb.sv
`default_nettype none
module charge_protect_alarm_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import charge_protect_pkg::*;

    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [15:0] battery_current_ma = 16'h1388;
    logic [15:0] input_voltage_mv = 16'h1388;
    logic host_irq;
    logic gate;
    logic [15:0] th;
    logic [7:0] fld;
    int err_count = 0;
    int n_compared = 0;

    always #2 ref_clk = ~ref_clk;

    charge_protect_alarm_regs charge_protect_alarm_regs_inst (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .battery_current_ma(battery_current_ma),
        .input_voltage_mv(input_voltage_mv),
        .host_irq(host_irq),
        .protection_fet_gate_drive(gate)
    );

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t pin=%h exp=%h", $time, got, exp);
        end
    endtask

    // one-cycle write strobe, no answer expected
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // data stands only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        cmp_byte(reg_rdata, exp);
    endtask

    // compare flop lags one edge and the flags land on the second; the third is slack
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask

    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard, well past the few hundred cycles the sequence needs
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        complete_run();
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        settle();
        cmp_bit(gate, 1'b1);
        rd(8'h04, 8'h28);
        rd(8'h05, 8'h03);
        rd(8'h20, 8'h00);
        // every threshold code; odd codes also carry the event mask
        for (int c = 0; c < 8; c++) begin
            th = (c == 7) ? OV_SPECIAL_MV : 16'(OV_BASE_MV + c * OV_STEP_MV);
            fld = {2'b00, c[0], 2'b00, c[2:0]};
            wr(8'h05, fld);
            input_voltage_mv <= th - 16'h0001;
            settle();
            cmp_bit(gate, 1'b1);
            rd(8'h05, fld);
            input_voltage_mv <= th;
            settle();
            cmp_bit(gate, 1'b0);
            cmp_bit(host_irq, ~c[0]);
            rd(8'h05, fld | 8'hc0);
            rd(8'h05, fld | 8'h80);
            rd(8'h10, c[0] ? 8'h00 : 8'h02);
            cmp_bit(host_irq, 1'b0);
            input_voltage_mv <= 16'h1388;
            settle();
            rd(8'h05, fld);
        end
        // read-only bits ignore writes
        wr(8'h05, 8'hff);
        rd(8'h05, 8'h27);
        wr(8'h10, 8'hff);
        rd(8'h10, 8'h00);
        // low-current alarm at 1000 mA: equal is not below
        wr(8'h04, 8'h14);
        rd(8'h04, 8'h14);
        battery_current_ma <= 16'h03e8;
        settle();
        cmp_bit(host_irq, 1'b0);
        battery_current_ma <= 16'h03e7;
        settle();
        cmp_bit(host_irq, 1'b1);
        rd(8'h10, 8'h01);
        cmp_bit(host_irq, 1'b0);
        // status still sticky while masked from the interrupt line
        battery_current_ma <= 16'h1388;
        wr(8'h11, 8'h01);
        battery_current_ma <= 16'h03e7;
        settle();
        cmp_bit(host_irq, 1'b0);
        rd(8'h10, 8'h01);
        // disable bit suppresses the event entirely
        battery_current_ma <= 16'h1388;
        wr(8'h11, 8'h00);
        wr(8'h04, 8'h94);
        battery_current_ma <= 16'h03e7;
        settle();
        cmp_bit(host_irq, 1'b0);
        rd(8'h10, 8'h00);
        // soft reset restores defaults
        wr(8'h05, 8'h24);
        wr(8'h11, 8'h03);
        wr(8'h12, 8'h01);
        rd(8'h04, 8'h28);
        rd(8'h05, 8'h03);
        rd(8'h11, 8'h00);
        rd(8'h12, 8'h00);
        complete_run();
    end
endmodule
`default_nettype wire
